// ==== logic/mrh_responder.sv ====
// serial holding-register read responder, slave side of the link
//
// Contract
// - slave only; never starts a transaction
// - four selectable bit rates, same both ends
// - start, 8 data lsb first, even parity, stop
// - only function three, read holding registers
// - read only; broadcast frames are ignored
// - own address 1..255; answer only it
// - default own address is 214
// - config port active stops all traffic
// - register packs two bytes, lower channel high
// - status codes small integers, 128 disabled
// - output current in tenths mA, zero disabled
`timescale 1ns/1ps
`default_nettype none
module mrh_responder
  import mrh_pkg::*;
#(
  parameter int CLK_FREQ = mrh_pkg::CLK_HZ,  // system clock in Hz
  parameter int TX_DEPTH = 4                 // transmit fifo words
) (
  input  wire logic       clock_i,           // system clock, 200 MHz
  input  wire logic       sys_rst_i,         // synchronous reset, high
  input  wire logic [1:0] baud_sel_i,        // bit rate select
  input  wire logic [7:0] slave_addr_i,      // own address, 0 = default
  input  wire logic       cfg_port_active_i, // config link owns the port
  input  wire logic       rxd_i,             // line receive, idle high
  output logic            txd_o,             // line transmit, idle high
  output logic            tx_en_o,           // line driver enable
  output logic      [7:0] byte_addr_o,       // status byte index
  input  wire logic [7:0] byte_i,            // status byte at that index
  output logic            req_ok_o,          // pulse: query accepted
  output logic            req_drop_o         // pulse: frame discarded
);
  import mrh_pkg::*;

  // ----------------------------------------------------------------------
  // bit rate and silence timing
  // ----------------------------------------------------------------------
  localparam int DIV_19K2 = CLK_FREQ / BAUD_19K2;  // clocks per bit
  localparam int DIV_28K8 = CLK_FREQ / BAUD_28K8;
  localparam int DIV_38K4 = CLK_FREQ / BAUD_38K4;
  localparam int DIV_57K6 = CLK_FREQ / BAUD_57K6;

  // the divider is truncated, so a bit
  // runs a shade short; a slow system
  // clock makes that error grow
  logic [15:0] bit_div;    // clocks per bit for the chosen rate
  logic [21:0] gap_limit;  // clocks of silence that end a frame

  // the rate is taken live; change it only while the line is quiet
  assign bit_div = (baud_sel_i == SEL_19K2) ? 16'(DIV_19K2) :
                   (baud_sel_i == SEL_28K8) ? 16'(DIV_28K8) :
                   (baud_sel_i == SEL_38K4) ? 16'(DIV_38K4) :
                                              16'(DIV_57K6);
  assign gap_limit = 22'(bit_div) * 22'(GAP_BITS);

  // ----------------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------------
  logic [7:0] rx_byte;   // received byte
  logic       rx_valid;  // clean byte pulse
  logic       rx_err;    // parity or framing fault pulse
  logic       rx_busy;   // character in progress

  // the receiver runs even while the
  // config link owns the pin; its bytes
  // only spoil the frame in progress
  mrh_uart_rx u_rx (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .rxd_i     (rxd_i),
    .div_i     (bit_div),
    .data_o    (rx_byte),
    .valid_o   (rx_valid),
    .err_o     (rx_err),
    .busy_o    (rx_busy)
  );

  // ----------------------------------------------------------------------
  // query collector
  // ----------------------------------------------------------------------
  mrh_rsp_state_t rsp_state;      // answer builder position
  logic           tx_busy;        // serializer is sending
  logic [7:0]     req [REQ_LEN];  // query bytes as received
  logic [3:0]     rx_cnt;         // bytes seen, saturates past a query
  logic [15:0]    rx_crc;         // running crc over every byte
  logic           rx_bad;         // frame already spoiled
  logic [21:0]    gap_cnt;        // clocks of silence so far
  logic           listen;         // frames may be taken now
  logic           frame_end;      // silence closed a frame
  logic [7:0]     my_addr;        // effective own address
  logic [8:0]     reg_end;        // start plus count
  logic           fields_ok;      // query fields within range
  logic           frame_ok;       // this frame is answered

  // the shared pin is ours only while the config link is idle and we are
  // not answering; half duplex, so our own echo is never parsed
  assign listen    = !cfg_port_active_i && (rsp_state == RS_IDLE) &&
                     !tx_busy;
  assign frame_end = (rx_cnt != 4'h0) && (gap_cnt >= gap_limit);
  assign my_addr   = (slave_addr_i == ADDR_BCAST) ? ADDR_DEFAULT
                                                   : slave_addr_i;
  assign reg_end   = {1'b0, req[3]} + {1'b0, req[5]};

  // a query outside the ranges the master must keep gets no answer
  assign fields_ok = (req[2] == 8'h00) && (req[3] <= START_MAX) &&
                     (req[4] == 8'h00) && (req[5] >= CNT_MIN) &&
                     (req[5] <= CNT_MAX) && (reg_end <= {1'b0, CNT_MAX});

  assign frame_ok  = frame_end && !rx_bad && listen &&
                     (rx_cnt == REQ_LEN) &&
                     (rx_crc == 16'h0000) &&
                     (req[0] != ADDR_BCAST) &&
                     (req[0] == my_addr) &&
                     (req[1] == FC_READ_HOLD) &&
                     fields_ok;

  // a frame is judged once it has ended,
  // so a long or short frame is dropped
  // as a whole and never answered
  // collect bytes until the line falls silent for 3.5 characters;
  // running the crc over the crc bytes too leaves zero when it matches
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rx_cnt  <= 4'h0;
      rx_crc  <= CRC_INIT;
      rx_bad  <= 1'b0;
      gap_cnt <= 22'h000000;
      for (int i = 0; i < REQ_LEN; i++) req[i] <= 8'h00;
    end else if (rx_valid || rx_err) begin
      gap_cnt <= 22'h000000;
      if (rx_cnt < REQ_LEN) req[rx_cnt[2:0]] <= rx_byte;
      if (rx_cnt <= REQ_LEN) rx_cnt <= rx_cnt + 4'h1;  // longer: spoiled
      rx_crc <= mrh_crc_byte(rx_crc, rx_byte);
      if (rx_err || !listen) rx_bad <= 1'b1;
    end else if (rx_busy || !rxd_i) begin
      gap_cnt <= 22'h000000;                           // line not silent
    end else if (frame_end) begin
      rx_cnt  <= 4'h0;                                 // ready for next
      rx_crc  <= CRC_INIT;
      rx_bad  <= 1'b0;
      gap_cnt <= 22'h000000;
    end else if (rx_cnt != 4'h0) begin
      gap_cnt <= gap_cnt + 22'h000001;
    end
  end

  // ----------------------------------------------------------------------
  // answer builder
  // ----------------------------------------------------------------------
  logic [1:0]  hdr_idx;    // header byte position
  logic [7:0]  bytes_left; // data bytes still to send
  logic [7:0]  byte_total; // data bytes in this answer
  logic [7:0]  rsp_addr;   // address echoed back
  logic [15:0] rsp_crc;    // crc over the answer so far
  logic [7:0]  rsp_byte;   // byte offered to the fifo
  logic        rsp_valid;  // builder has a byte
  logic        fifo_ready; // fifo can take it
  logic        rsp_push;   // byte moves this cycle

  // the builder never watches the line;
  // it only ever follows frame_ok
  // the answer is assembled only after a query has been accepted; the
  // block never speaks first
  assign rsp_valid = (rsp_state != RS_IDLE);
  assign rsp_push  = rsp_valid && fifo_ready;

  // header, then data straight from the status port, then crc low first
  assign rsp_byte =
    (rsp_state == RS_HDR)  ? ((hdr_idx == 2'h0) ? rsp_addr :
                              (hdr_idx == 2'h1) ? FC_READ_HOLD :
                                                  byte_total) :
    (rsp_state == RS_DATA) ? byte_i :
    (rsp_state == RS_CRCL) ? rsp_crc[7:0] :
                             rsp_crc[15:8];

  // byte_i must settle in the cycle its
  // index is shown; the status port has
  // no wait state
  // register n is status bytes 2n (high, lower channel) and 2n+1 (low);
  // the byte port follows the channel order so no swapping is needed
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rsp_state   <= RS_IDLE;
      hdr_idx     <= 2'h0;
      bytes_left  <= 8'h00;
      byte_total  <= 8'h00;
      rsp_addr    <= 8'h00;
      rsp_crc     <= CRC_INIT;
      byte_addr_o <= 8'h00;
    end else begin
      unique case (rsp_state)
        RS_IDLE: if (frame_ok) begin
          rsp_state   <= RS_HDR;
          hdr_idx     <= 2'h0;
          rsp_addr    <= req[0];
          rsp_crc     <= CRC_INIT;
          byte_addr_o <= {req[3][6:0], 1'b0};
          bytes_left  <= {req[5][6:0], 1'b0};
          byte_total  <= {req[5][6:0], 1'b0};
        end
        RS_HDR: if (rsp_push) begin
          rsp_crc <= mrh_crc_byte(rsp_crc, rsp_byte);
          hdr_idx <= hdr_idx + 2'h1;
          if (hdr_idx == HDR_LEN - 2'h1) rsp_state <= RS_DATA;
        end
        RS_DATA: if (rsp_push) begin
          rsp_crc     <= mrh_crc_byte(rsp_crc, rsp_byte);
          byte_addr_o <= byte_addr_o + 8'h01;
          bytes_left  <= bytes_left - 8'h01;
          if (bytes_left == 8'h01) rsp_state <= RS_CRCL;
        end
        RS_CRCL: if (rsp_push) rsp_state <= RS_CRCH;
        RS_CRCH: if (rsp_push) rsp_state <= RS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // transmit fifo: the builder stalls while it is full
  // ----------------------------------------------------------------------
  logic [7:0] tx_byte;   // oldest byte waiting
  logic       tx_avail;  // fifo not empty
  logic       tx_take;   // serializer loads a byte

  // four bytes of slack let the builder
  // run ahead of the line and read the
  // status port at its own pace
  assign tx_take = tx_avail && !tx_busy;

  mrh_fifo #(
    .WIDTH (8),
    .DEPTH (TX_DEPTH)
  ) u_txq (
    .clock_i     (clock_i),
    .sys_rst_i   (sys_rst_i),
    .in_data_i   (rsp_byte),
    .in_valid_i  (rsp_valid),
    .in_ready_o  (fifo_ready),
    .out_data_o  (tx_byte),
    .out_valid_o (tx_avail),
    .out_ready_i (!tx_busy)
  );

  // ----------------------------------------------------------------------
  // serializer
  // ----------------------------------------------------------------------
  logic [CHAR_BITS-1:0] tx_sh;    // stop, parity, data, start
  logic [3:0]           tx_left;  // bits still on the line
  logic [15:0]          tx_cnt;   // clocks left in this bit

  // tx_left counts the stop bit too, so
  // busy covers the whole character
  assign tx_busy = (tx_left != 4'h0);

  // each character: start, data lsb first, even parity, one stop
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tx_sh   <= '1;
      tx_left <= 4'h0;
      tx_cnt  <= 16'h0000;
      txd_o   <= 1'b1;
    end else if (tx_take) begin
      tx_sh   <= {1'b1, ^tx_byte, tx_byte, 1'b0};
      tx_left <= 4'(CHAR_BITS);
      tx_cnt  <= bit_div - 16'h0001;
      txd_o   <= 1'b0;                                      // start bit
    end else if (tx_busy) begin
      if (tx_cnt != 16'h0000) begin
        tx_cnt <= tx_cnt - 16'h0001;
      end else begin
        tx_sh   <= {1'b1, tx_sh[CHAR_BITS-1:1]};
        tx_left <= tx_left - 4'h1;
        tx_cnt  <= bit_div - 16'h0001;
        txd_o   <= (tx_left == 4'h1) ? 1'b1 : tx_sh[1];
      end
    end
  end

  // ----------------------------------------------------------------------
  // driver enable and event pulses
  // ----------------------------------------------------------------------
  // limitation: a config request made
  // mid-answer mutes the driver, but
  // the builder still runs to the end
  // the driver stays on from acceptance to the end of the last stop bit,
  // and turns off one cycle after the config link takes the pin
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tx_en_o    <= 1'b0;
      req_ok_o   <= 1'b0;
      req_drop_o <= 1'b0;
    end else begin
      tx_en_o    <= !cfg_port_active_i &&
                    (rsp_valid || tx_avail || tx_busy || frame_ok);
      req_ok_o   <= frame_ok;
      req_drop_o <= frame_end && !frame_ok;
    end
  end
endmodule // mrh_responder
`default_nettype wire

// ==== logic/mrh_pkg.sv ====
// shared constants, types and crc helper for the holding-register responder
package mrh_pkg;
  // ----------------------------------------------------------------------
  // clock and line rates
  // ----------------------------------------------------------------------
  localparam int CLK_HZ     = 200_000_000;  // system clock, 5 ns period
  localparam int BAUD_19K2  = 19_200;       // rate select 0
  localparam int BAUD_28K8  = 28_800;       // rate select 1
  localparam int BAUD_38K4  = 38_400;       // rate select 2
  localparam int BAUD_57K6  = 57_600;       // rate select 3
  localparam logic [1:0] SEL_19K2 = 2'h0;
  localparam logic [1:0] SEL_28K8 = 2'h1;
  localparam logic [1:0] SEL_38K4 = 2'h2;
  localparam int CHAR_BITS  = 11;  // start, 8 data, parity, stop
  localparam int DATA_BITS  = 8;
  localparam int GAP_BITS   = 39;  // 3.5 characters of silence, rounded up

  // ----------------------------------------------------------------------
  // protocol values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  ADDR_BCAST    = 8'h00;  // broadcast address
  localparam logic [7:0]  ADDR_DEFAULT  = 8'hD6;  // 214 when unset
  localparam logic [7:0]  FC_READ_HOLD  = 8'h03;  // only function served
  localparam logic [7:0]  START_MAX     = 8'h7A;  // 122
  localparam logic [7:0]  CNT_MIN       = 8'h01;
  localparam logic [7:0]  CNT_MAX       = 8'h7B;  // 123
  localparam logic [3:0]  REQ_LEN       = 4'h8;   // bytes in a query
  localparam logic [1:0]  HDR_LEN       = 2'h3;   // addr, fc, byte count
  localparam logic [15:0] CRC_INIT      = 16'hFFFF;
  localparam logic [15:0] CRC_POLY      = 16'hA001; // reflected 0x8005

  // ----------------------------------------------------------------------
  // status byte codes served from the holding registers
  // ----------------------------------------------------------------------
  localparam logic [7:0] STAT_NORMAL   = 8'h00;
  localparam logic [7:0] STAT_ALARM    = 8'h01;
  localparam logic [7:0] STAT_COMM_ERR = 8'h02;
  localparam logic [7:0] STAT_OFFLINE  = 8'h03;
  localparam logic [7:0] STAT_ON_DLY   = 8'h05;
  localparam logic [7:0] STAT_OFF_DLY  = 8'h06;
  localparam logic [7:0] STAT_LATCHED  = 8'h07;
  localparam logic [7:0] STAT_ON       = 8'h08;
  localparam logic [7:0] STAT_OFF      = 8'h09;
  localparam logic [7:0] STAT_NO_ASGN  = 8'h0C;
  localparam logic [7:0] STAT_HUSHED   = 8'h0D;
  localparam logic [7:0] STAT_DISABLED = 8'h80;
  localparam logic [7:0] AOUT_DISABLED = 8'h00;  // else mA times ten

  // ----------------------------------------------------------------------
  // state types, gray coded along the usual path
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b011,
    RX_PAR  = 3'b010, RX_STOP  = 3'b110
  } mrh_rx_state_t;

  typedef enum logic [2:0] {
    RS_IDLE = 3'b000, RS_HDR  = 3'b001, RS_DATA = 3'b011,
    RS_CRCL = 3'b010, RS_CRCH = 3'b110
  } mrh_rsp_state_t;

  // one byte through the reflected crc-16
  function automatic logic [15:0] mrh_crc_byte(input logic [15:0] c,
                                               input logic [7:0]  d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
endpackage

// ==== logic/mrh_uart_rx.sv ====
// receive side of the serial line: 8 data bits, even parity, one stop
`timescale 1ns/1ps
`default_nettype none
module mrh_uart_rx
  import mrh_pkg::*;
(
  input  wire logic        clock_i,   // system clock
  input  wire logic        sys_rst_i, // synchronous reset, high
  input  wire logic        rxd_i,     // line in, idle high
  input  wire logic [15:0] div_i,     // clocks per bit
  output logic      [7:0]  data_o,    // received byte
  output logic             valid_o,   // pulse: clean byte
  output logic             err_o,     // pulse: parity or framing fault
  output logic             busy_o     // a character is in progress
);
  mrh_rx_state_t state;   // bit position
  logic [15:0]   cnt;     // clocks to next sample
  logic [2:0]    nbit;    // data bit index
  logic [7:0]    shreg;   // data assembled lsb first
  logic          par;     // parity bit as sampled

  assign busy_o = (state != RX_IDLE);

  // ----------------------------------------------------------------------
  // sampler: starts on the falling edge, samples mid bit
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    valid_o <= 1'b0;
    err_o   <= 1'b0;
    if (sys_rst_i) begin
      state  <= RX_IDLE;
      cnt    <= 16'h0000;
      nbit   <= 3'h0;
      shreg  <= 8'h00;
      par    <= 1'b0;
      data_o <= 8'h00;
    end else if (state == RX_IDLE) begin
      if (!rxd_i) begin                 // start edge: wait half a bit
        state <= RX_START;
        cnt   <= div_i >> 1;
      end
    end else if (cnt != 16'h0000) begin
      cnt <= cnt - 16'h0001;
    end else begin
      cnt <= div_i - 16'h0001;
      unique case (state)
        RX_START: begin                 // a glitch shorter than half a bit
          state <= rxd_i ? RX_IDLE : RX_DATA;
          nbit  <= 3'h0;
        end
        RX_DATA: begin                  // lsb arrives first
          shreg <= {rxd_i, shreg[7:1]};
          nbit  <= nbit + 3'h1;
          if (nbit == 3'(DATA_BITS - 1)) state <= RX_PAR;
        end
        RX_PAR: begin
          par   <= rxd_i;
          state <= RX_STOP;
        end
        default: begin                  // stop bit, checks even parity
          state  <= RX_IDLE;
          data_o <= shreg;
          if ((^{shreg, par}) || !rxd_i) err_o <= 1'b1;
          else valid_o <= 1'b1;
        end
      endcase
    end
  end
endmodule // mrh_uart_rx
`default_nettype wire

// ==== logic/mrh_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module mrh_fifo #(
  parameter int WIDTH = 8,  // word width
  parameter int DEPTH = 4   // words, a power of two
) (
  input  wire logic             clock_i,   // system clock
  input  wire logic             sys_rst_i, // synchronous reset, high
  input  wire logic [WIDTH-1:0] in_data_i, // word to store
  input  wire logic             in_valid_i,// source offers a word
  output logic                  in_ready_o,// not full
  output logic      [WIDTH-1:0] out_data_o,// oldest word
  output logic                  out_valid_o,// not empty
  input  wire logic             out_ready_i // sink takes the word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // storage
  logic [AW:0]      wr_ptr;       // extra bit tells full from empty
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready_o  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign out_valid_o = (wr_ptr != rd_ptr);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];

  // ----------------------------------------------------------------------
  // pointers and storage
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + (AW+1)'(1);
      if (pop)  rd_ptr <= rd_ptr + (AW+1)'(1);
    end
  end

  // memory has no reset: contents are only read once written
  always_ff @(posedge clock_i) begin
    if (push) mem[wr_ptr[AW-1:0]] <= in_data_i;
  end
endmodule // mrh_fifo
`default_nettype wire

// ==== tb/mrh_host_model.sv ====
// host master model: drives queries and reads answers on the line
`timescale 1ns/1ps
`default_nettype none
module mrh_host_model (
  input  wire logic clock_i, // system clock
  input  wire logic txd_i,   // device transmit line
  output var  logic rxd_o    // device receive line
);
  int div = 20; // clocks per bit, same rate as the device
  initial rxd_o = 1'b1; // line idles high
  // ----------------------------------------------------------------------
  // crc over a byte list, init ffff, reflected poly
  // ----------------------------------------------------------------------
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction
  // one character lsb first, even parity; bad_p flips it
  task automatic put(input logic [7:0] d, input logic bad_p);
    logic [10:0] f;
    f = {1'b1, ^d ^ bad_p, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd_o <= f[i];
      repeat (div) @(posedge clock_i);
    end
  endtask
  // read one character; ok low on timeout, framing or parity fault
  task automatic get(output logic [7:0] d, output logic ok);
    logic [10:0] f;
    int n;
    n = 0;
    while (txd_i !== 1'b0 && n < 4000) begin
      @(posedge clock_i);
      n++;
    end
    repeat (div / 2) @(posedge clock_i); // sample mid-bit
    for (int i = 0; i < 11; i++) begin
      f[i] = txd_i;
      if (i < 10) repeat (div) @(posedge clock_i);
    end
    d = f[8:1];
    ok = (n < 4000) && !f[0] && f[10] && !(^f[9:1]);
  endtask
endmodule // mrh_host_model
`default_nettype wire

// ==== tb/mrh_responder_properties.sv ====
// concurrent checks on the responder's line and status ports
`timescale 1ns/1ps
`default_nettype none
module mrh_responder_properties #(
  parameter int CLK_FREQ = 200_000_000 // system clock in Hz
) (
  input wire logic       clock_i,           // system clock
  input wire logic       sys_rst_i,         // synchronous reset
  input wire logic       cfg_port_active_i, // config link owns port
  input wire logic       txd_o,             // line transmit
  input wire logic       tx_en_o,           // driver enable
  input wire logic [7:0] byte_addr_o,       // status byte index
  input wire logic       req_ok_o,          // query accepted
  input wire logic       req_drop_o         // frame discarded
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // answer opens with a start bit shortly after the driver turns on
  sequence s_lead;
    tx_en_o ##[1:6] !txd_o;
  endsequence
  a_idle_high: assert property (!tx_en_o |-> txd_o)
    else $error("line low while driver off");
  a_cfg_quiet: assert property (cfg_port_active_i |=> !req_ok_o)
    else $error("answer while config port active");
  a_ok_starts: assert property (req_ok_o |-> s_lead)
    else $error("no start bit after accept");
  a_ok_single: assert property (req_ok_o |=> !req_ok_o)
    else $error("accept pulse too long");
  a_drop_alone: assert property (req_drop_o |-> !req_ok_o && !tx_en_o)
    else $error("frame both accepted and dropped");
  a_en_cause: assert property ($rose(tx_en_o) |-> req_ok_o)
    else $error("driver on without a query");
  a_en_holds: assert property (req_ok_o |=> tx_en_o [*8])
    else $error("driver dropped early");
  a_bit_len: assert property ($changed(txd_o) |=> $stable(txd_o) [*8])
    else $error("bit shorter than a bit time");
  a_addr_step: assert property ($changed(byte_addr_o) && !req_ok_o
    |-> byte_addr_o == $past(byte_addr_o) + 8'h01)
    else $error("status index not increasing by one");
endmodule // mrh_responder_properties
bind mrh_responder mrh_responder_properties #(.CLK_FREQ(CLK_FREQ)) i_props (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .cfg_port_active_i(cfg_port_active_i), .txd_o(txd_o), .tx_en_o(tx_en_o),
  .byte_addr_o(byte_addr_o), .req_ok_o(req_ok_o), .req_drop_o(req_drop_o));
`default_nettype wire

// ==== tb/mrh_responder_tb_top.sv ====
// self-checking bench for the holding-register responder
`timescale 1ns/1ps
`default_nettype none
module mrh_responder_tb_top;
  import mrh_pkg::*;
  localparam int FREQ = 1_152_000; // 60/40/30/20 clocks per bit
  logic       clock_i = 1'b0, sys_rst_i = 1'b1, cfg = 1'b0;
  logic [1:0] sel = 2'h3;
  logic [7:0] own = 8'h00, key = 8'h00, baddr, sbyte;
  wire        txd, txen, rxd, ok, drop;
  int         fail_count = 0, n_checks = 0;
  // bad queries: address, function, start, count
  logic [31:0] bad [10] = '{32'h00030001, 32'hD6030001, 32'h2C060001,
    32'h2C037B01, 32'h2C030000, 32'h2C03007C, 32'h2C037A02, 32'h2C030001,
    32'h2C030001, 32'h2C030001};
  initial forever #2.5 clock_i = ~clock_i;
  assign sbyte = baddr ^ key; // status content follows the index
  mrh_responder #(.CLK_FREQ(FREQ)) i_dut (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .baud_sel_i(sel), .slave_addr_i(own),
    .cfg_port_active_i(cfg), .rxd_i(rxd), .txd_o(txd), .tx_en_o(txen),
    .byte_addr_o(baddr), .byte_i(sbyte), .req_ok_o(ok), .req_drop_o(drop));
  mrh_host_model i_host (.clock_i(clock_i), .txd_i(txd), .rxd_o(rxd));
  task automatic chk(input string what, input logic [8:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // send one query, optionally corrupted, and wait for its outcome
  task automatic query(input logic [7:0] a, fc, st, cn, input logic xc,
                       input int bp, output logic g_ok, g_dr);
    logic [7:0]  q[$];
    logic [15:0] c;
    q = '{a, fc, 8'h00, st, 8'h00, cn};
    c = i_host.crc16(q) ^ {15'h0000, xc};
    q.push_back(c[7:0]); // crc low byte first
    q.push_back(c[15:8]);
    foreach (q[i]) i_host.put(q[i], i == bp);
    g_ok = 1'b0;
    g_dr = 1'b0;
    for (int n = 0; n < 40 * i_host.div + 50 && !g_ok && !g_dr; n++) begin
      @(posedge clock_i);
      #1 g_ok = ok;
      g_dr = drop;
    end
    @(posedge clock_i);
    if (!g_ok && !g_dr) begin
      fail_count++;
      $display("[ERR] outcome expected pulse seen none");
      wrap_up();
    end
  endtask
  // legal read; every answer byte compared with the expected frame
  task automatic read_test(input logic [7:0] st, cn);
    logic       g_ok, g_dr, okb;
    logic [7:0] a, d, e[$];
    logic [15:0] c;
    a = (own == 8'h00) ? 8'hD6 : own;
    query(a, 8'h03, st, cn, 1'b0, -1, g_ok, g_dr);
    chk("accept", 9'h001, {8'h00, g_ok});
    e = '{a, 8'h03, {cn[6:0], 1'b0}};
    for (int i = 0; i < 2 * cn; i++) e.push_back(8'(2 * st + i) ^ key);
    c = i_host.crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    foreach (e[i]) begin
      i_host.get(d, okb);
      chk("answer byte", {1'b1, e[i]}, {okb, d});
    end
    repeat (i_host.div) @(posedge clock_i);
    chk("driver off", 9'h000, {8'h00, txen});
  endtask
  initial begin
    logic g_ok, g_dr;
    void'($urandom(29321));
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    // every rate, default address, random window and content
    for (int s = 0; s < 4; s++) begin
      sel <= 2'(s);
      i_host.div = FREQ / (s == 0 ? 19200 : s == 1 ? 28800 :
                           s == 2 ? 38400 : 57600);
      key <= 8'($urandom);
      @(posedge clock_i);
      read_test(8'($urandom_range(0, 120)), 8'($urandom_range(1, 3)));
      $display("rate test %0d done", s);
    end
    // own address set, top start and longest window kept short
    own <= 8'h2C;
    @(posedge clock_i);
    read_test(8'h7A, 8'h01);
    read_test(8'h00, 8'h03);
    $display("address test done");
    // refused frames: each must be dropped without an answer
    for (int i = 0; i < 10; i++) begin
      cfg <= (i == 9);
      @(posedge clock_i);
      query(bad[i][31:24], bad[i][23:16], bad[i][15:8], bad[i][7:0],
            i == 7, i == 8 ? 3 : -1, g_ok, g_dr);
      chk("refused", 9'h001, {7'h00, g_ok, g_dr});
    end
    cfg <= 1'b0;
    $display("refusal test done");
    read_test(8'h10, 8'h02);
    $display("recovery test done");
    wrap_up();
  end
endmodule // mrh_responder_tb_top
`default_nettype wire
